// File: shared/offset_gain_calibration_regs.svh
`ifndef OFFSET_GAIN_CALIBRATION_REGS_SVH
`define OFFSET_GAIN_CALIBRATION_REGS_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define CAL_OFFSET_UPPER_ADDR 8'h21
`define CAL_OFFSET_MIDDLE_ADDR 8'h22
`define CAL_OFFSET_LOWER_ADDR 8'h23
`define CAL_SCALE_UPPER_ADDR 8'h24
`define CAL_SCALE_MIDDLE_ADDR 8'h25
`define CAL_SCALE_LOWER_ADDR 8'h26

// ----------------------------------------------------------------------
// reset values and arithmetic layout
// ----------------------------------------------------------------------
`define CAL_OFFSET_RESET 24'h000000
`define CAL_SCALE_NOMINAL 24'h555555
`define CAL_UNMAPPED_READ 8'h00
`define CAL_SCALE_SHIFT 22
`define CAL_SAT_POS 24'h7FFFFF
`define CAL_SAT_NEG 24'h800000
`define CAL_FIFO_DEPTH 8

`endif

// File: shared/offset_gain_calibration_pkg.sv
package offset_gain_calibration_pkg;

  typedef logic [7:0]  reg_addr_t;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [23:0] coeff_t;
  typedef logic [23:0] sample_t;

endpackage : offset_gain_calibration_pkg

// File: design/offset_gain_calibration.sv

`include "offset_gain_calibration_regs.svh"

// ----------------------------------------------------------------------
// output fifo
// ----------------------------------------------------------------------
module cal_sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  assign full         = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty        = (wr_ptr == rd_ptr);
  assign wr_ready_out = ce_in && !full;
  assign rd_valid_out = !empty;
  assign rd_data_out  = mem[rd_ptr[AW-1:0]];
  assign push         = wr_valid_in && wr_ready_out;
  assign pop          = ce_in && rd_ready_in && !empty;

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : cal_sample_fifo

// ----------------------------------------------------------------------
// calibration top
// ----------------------------------------------------------------------
module offset_gain_calibration #(
  parameter offset_gain_calibration_pkg::coeff_t FACTORY_SCALE = `CAL_SCALE_NOMINAL
) (
  input  wire logic                                 ref_clk_in,
  input  wire logic                                 rst_in,
  input  wire logic                                 ce_in,
  input  wire offset_gain_calibration_pkg::reg_addr_t reg_addr_in,
  input  wire offset_gain_calibration_pkg::reg_byte_t reg_wdata_in,
  input  wire logic                                 reg_wr_in,
  input  wire logic                                 reg_rd_in,
  output offset_gain_calibration_pkg::reg_byte_t    reg_rdata_out,
  input  wire offset_gain_calibration_pkg::sample_t   sample_in,
  input  wire logic                                 sample_valid_in,
  output logic                                      sample_ready_out,
  output offset_gain_calibration_pkg::sample_t      corrected_out,
  output logic                                      corrected_valid_out,
  input  wire logic                                 corrected_ready_in
);
  import offset_gain_calibration_pkg::*;

  coeff_t             offset;
  coeff_t             scale;
  logic signed [24:0] diff_q;
  logic               diff_valid;
  sample_t            result_q;
  logic               result_valid;
  logic               fifo_ready;
  logic               adv_result;
  logic               adv_diff;
  logic               accept;
  logic signed [24:0] next_diff;
  logic signed [49:0] product;
  logic signed [49:0] shifted;
  sample_t            next_result;
  reg_byte_t          next_rdata;

  // ----------------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------------
  // sync reset overrides the clock enable so a frozen block still resets
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      offset <= `CAL_OFFSET_RESET;
    end else if (ce_in && reg_wr_in) begin
      case (reg_addr_in)
        `CAL_OFFSET_UPPER_ADDR:  offset[23:16] <= reg_wdata_in;
        `CAL_OFFSET_MIDDLE_ADDR: offset[15:8]  <= reg_wdata_in;
        `CAL_OFFSET_LOWER_ADDR:  offset[7:0]   <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // the factory value stands in for fuse storage, reloaded on every reset
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      scale <= FACTORY_SCALE;
    end else if (ce_in && reg_wr_in) begin
      case (reg_addr_in)
        `CAL_SCALE_UPPER_ADDR:  scale[23:16] <= reg_wdata_in;
        `CAL_SCALE_MIDDLE_ADDR: scale[15:8]  <= reg_wdata_in;
        `CAL_SCALE_LOWER_ADDR:  scale[7:0]   <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  always_comb begin
    case (reg_addr_in)
      `CAL_OFFSET_UPPER_ADDR:  next_rdata = offset[23:16];
      `CAL_OFFSET_MIDDLE_ADDR: next_rdata = offset[15:8];
      `CAL_OFFSET_LOWER_ADDR:  next_rdata = offset[7:0];
      `CAL_SCALE_UPPER_ADDR:   next_rdata = scale[23:16];
      `CAL_SCALE_MIDDLE_ADDR:  next_rdata = scale[15:8];
      `CAL_SCALE_LOWER_ADDR:   next_rdata = scale[7:0];
      default:                 next_rdata = `CAL_UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= `CAL_UNMAPPED_READ;
    end else if (ce_in && reg_rd_in) begin
      reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // datapath: offset stage, then scale stage
  // ----------------------------------------------------------------------
  assign adv_result       = ce_in && (!result_valid || fifo_ready);
  assign adv_diff         = ce_in && (!diff_valid || adv_result);
  assign sample_ready_out = adv_diff;
  assign accept           = sample_valid_in && adv_diff;

  // one extra bit keeps the subtraction from wrapping
  assign next_diff = $signed({sample_in[23], sample_in}) - $signed({offset[23], offset});

  // scale is unsigned; nominal 1/3 of 2^24 through the 2^22 shift gives a gain of 4/3
  assign product = diff_q * $signed({1'b0, scale});
  assign shifted = product >>> `CAL_SCALE_SHIFT;

  always_comb begin
    if ((&shifted[49:23]) || !(|shifted[49:23])) begin
      next_result = shifted[23:0];
    end else if (shifted[49]) begin
      next_result = `CAL_SAT_NEG;
    end else begin
      next_result = `CAL_SAT_POS;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      diff_q     <= '0;
      diff_valid <= 1'b0;
    end else if (adv_diff) begin
      diff_valid <= sample_valid_in;
      if (sample_valid_in) begin
        diff_q <= next_diff;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      result_q     <= '0;
      result_valid <= 1'b0;
    end else if (adv_result) begin
      result_valid <= diff_valid;
      if (diff_valid) begin
        result_q <= next_result;
      end
    end
  end

  // fifo ready stalls both stages, which in turn drops sample_ready_out
  cal_sample_fifo #(
    .WIDTH (24),
    .DEPTH (`CAL_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in   (ref_clk_in),
    .rst_in       (rst_in),
    .ce_in        (ce_in),
    .wr_data_in   (result_q),
    .wr_valid_in  (result_valid),
    .wr_ready_out (fifo_ready),
    .rd_data_out  (corrected_out),
    .rd_valid_out (corrected_valid_out),
    .rd_ready_in  (corrected_ready_in)
  );

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  property p_offset_upper_read;
    ce_in && reg_rd_in && reg_addr_in == `CAL_OFFSET_UPPER_ADDR
      |=> reg_rdata_out == $past(offset[23:16]);
  endproperty
  a_offset_upper_read: assert property (p_offset_upper_read) else $error("offset upper read");

  property p_offset_middle_write;
    ce_in && reg_wr_in && reg_addr_in == `CAL_OFFSET_MIDDLE_ADDR
      |=> offset[15:8] == $past(reg_wdata_in) && offset[23:16] == $past(offset[23:16]);
  endproperty
  a_offset_middle_write: assert property (p_offset_middle_write) else $error("offset mid write");

  property p_nominal_step;
    diff_valid && adv_result && scale == `CAL_SCALE_NOMINAL && diff_q == -25'sd3
      |=> result_q == 24'hFFFFFC;
  endproperty
  a_nominal_step: assert property (p_nominal_step) else $error("nominal step not -4/3");

  property p_offset_first;
    accept |=> diff_q == $signed({$past(sample_in[23]), $past(sample_in)})
                         - $signed({$past(offset[23]), $past(offset)});
  endproperty
  a_offset_first: assert property (p_offset_first) else $error("offset not subtracted");

  property p_double_scale;
    diff_valid && adv_result && scale == 24'hAAAAAA && diff_q == -25'sd3
      |=> result_q == 24'hFFFFF8;
  endproperty
  a_double_scale: assert property (p_double_scale) else $error("step not linear in scale");

  property p_reset_values;
    $fell(rst_in) |-> offset == `CAL_OFFSET_RESET && scale == FACTORY_SCALE;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad coefficient reset");

  property p_scale_upper_write;
    ce_in && reg_wr_in && reg_addr_in == `CAL_SCALE_UPPER_ADDR
      |=> scale[23:16] == $past(reg_wdata_in) && scale[15:0] == $past(scale[15:0]);
  endproperty
  a_scale_upper_write: assert property (p_scale_upper_write) else $error("scale write lost");

  property p_scale_upper_read;
    ce_in && reg_rd_in && reg_addr_in == `CAL_SCALE_UPPER_ADDR
      |=> reg_rdata_out == $past(scale[23:16]);
  endproperty
  a_scale_upper_read: assert property (p_scale_upper_read) else $error("scale read wrong");

  property p_scale_lower_write;
    ce_in && reg_wr_in && reg_addr_in == `CAL_SCALE_LOWER_ADDR
      |=> scale[7:0] == $past(reg_wdata_in) && scale[23:8] == $past(scale[23:8]);
  endproperty
  a_scale_lower_write: assert property (p_scale_lower_write) else $error("scale lower write");

  property p_every_sample;
    accept |=> diff_valid;
  endproperty
  a_every_sample: assert property (p_every_sample) else $error("sample dropped");

  property p_stage_handoff;
    diff_valid && adv_result |=> result_valid && result_q == $past(next_result);
  endproperty
  a_stage_handoff: assert property (p_stage_handoff) else $error("stage handoff lost");

  property p_freeze;
    !ce_in |=> $stable(offset) && $stable(scale) && $stable(result_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");

  c_output_taken: cover property (corrected_valid_out && corrected_ready_in && ce_in);
  c_fifo_fills:   cover property (!fifo_ready && ce_in);
  c_saturated:    cover property (diff_valid && adv_result && next_result == `CAL_SAT_POS);
  c_scale_write:  cover property (ce_in && reg_wr_in && reg_addr_in == `CAL_SCALE_MIDDLE_ADDR);
endmodule : offset_gain_calibration

// File: sim/tb_top.sv
`include "offset_gain_calibration_regs.svh"

module tb_top import offset_gain_calibration_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic      ref_clk_in, rst_in, ce_in, reg_wr_in, reg_rd_in;
  reg_addr_t reg_addr_in;
  reg_byte_t reg_wdata_in, reg_rdata_out;
  sample_t   sample_in, corrected_out;
  logic      sample_valid_in, sample_ready_out, corrected_valid_out, corrected_ready_in;
  int        n_mismatch, tests_run, cyc, n;
  logic [31:0] seed;
  logic [31:0] rnd_word;
  logic      rnd_on;
  coeff_t    off_m, scl_m;
  sample_t   exp_q[$];

  offset_gain_calibration dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .sample_in(sample_in),
    .sample_valid_in(sample_valid_in), .sample_ready_out(sample_ready_out),
    .corrected_out(corrected_out), .corrected_valid_out(corrected_valid_out),
    .corrected_ready_in(corrected_ready_in));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // offset first, then unsigned scale, floor shift, saturate
  function automatic sample_t calc(sample_t s, coeff_t o, coeff_t g);
    longint p;
    p = (longint'($signed(s)) - longint'($signed(o))) * longint'(g);
    p = p >>> `CAL_SCALE_SHIFT;
    if (p > 64'sh7FFFFF) return `CAL_SAT_POS;
    if (p < -64'sh800000) return `CAL_SAT_NEG;
    return p[23:0];
  endfunction : calc

  task automatic check(string nm, logic [23:0] seen, logic [23:0] expv);
    tests_run++;
    if (seen !== expv) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, expv, seen);
    end
  endtask : check

  task automatic test_done();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  task automatic reg_wr(reg_addr_t a, reg_byte_t d);
    @(posedge ref_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(reg_addr_t a, reg_byte_t e);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in   <= 1'b0;
    @(negedge ref_clk_in);
    check("reg_rdata_out", {16'h0000, reg_rdata_out}, {16'h0000, e});
  endtask : reg_rd

  task automatic set_coeffs(coeff_t o, coeff_t g);
    off_m = o;
    scl_m = g;
    for (int i = 0; i < 3; i++) begin
      reg_wr(8'h21 + 8'(i), o[23-8*i -: 8]);
      reg_wr(8'h24 + 8'(i), g[23-8*i -: 8]);
    end
  endtask : set_coeffs

  task automatic send(sample_t s);
    @(posedge ref_clk_in);
    sample_in       <= s;
    sample_valid_in <= 1'b1;
    do @(posedge ref_clk_in); while (!sample_ready_out);
    exp_q.push_back(calc(s, off_m, scl_m));
    sample_valid_in <= 1'b0;
  endtask : send

  task automatic drain();
    for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge ref_clk_in);
    check("pending", 24'(exp_q.size()), 24'h000000);
  endtask : drain

  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  // ----------------------------------------------------------------------
  // consumer scoreboard, stall and clock-enable noise, timeout
  // ----------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (!rst_in && corrected_valid_out && corrected_ready_in && ce_in) begin
      if (exp_q.size() == 0) check("extra output", 24'h000001, 24'h000000);
      else check("corrected_out", corrected_out, exp_q.pop_front());
    end
    if (rnd_on) begin
      rnd_word           = rnd();
      ce_in              <= |rnd_word[1:0];
      corrected_ready_in <= rnd_word[2];
    end
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    seed = 32'h00000044;
    n_mismatch = 0; tests_run = 0; cyc = 0; rnd_on = 1'b0;
    rst_in = 1'b1; ce_in = 1'b1; reg_wr_in = 1'b0; reg_rd_in = 1'b0;
    reg_addr_in = 8'h00; reg_wdata_in = 8'h00; sample_in = 24'h000000;
    sample_valid_in = 1'b0; corrected_ready_in = 1'b1;
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    // reset contents, neighbours of the map read as zero
    for (int a = 8'h20; a <= 8'h27; a++)
      reg_rd(8'(a), (a >= 8'h24 && a <= 8'h26) ? 8'h55 : 8'h00);
    // writes while the clock enable is low are lost
    @(posedge ref_clk_in) ce_in <= 1'b0;
    reg_wr(8'h21, 8'hAB);
    @(posedge ref_clk_in) ce_in <= 1'b1;
    reg_rd(8'h21, 8'h00);
    // every coefficient byte keeps what was written
    for (int i = 0; i < 6; i++) begin
      n = rnd() & 8'hFF;
      reg_wr(8'h21 + 8'(i), 8'(n));
      reg_rd(8'h21 + 8'(i), 8'(n));
    end
    // zero offset, one hundred counts, doubled scale, random pair
    for (int c = 0; c < 4; c++) begin
      case (c)
        0: set_coeffs(24'h000000, `CAL_SCALE_NOMINAL);
        1: set_coeffs(24'h000064, `CAL_SCALE_NOMINAL);
        2: set_coeffs(24'h000064, 24'hAAAAAA);
        default: set_coeffs(24'(rnd()), 24'(rnd()));
      endcase
      send(24'h000000);
      send(24'h7FFFFF);
      send(24'h800000);
      send(24'h000061);
      @(posedge ref_clk_in) rnd_on <= 1'b1;
      repeat (30) send(24'(rnd()));
      @(posedge ref_clk_in) rnd_on <= 1'b0;
      // let the noise process see rnd_on low before taking ce and ready back
      @(posedge ref_clk_in);
      ce_in <= 1'b1;
      corrected_ready_in <= 1'b1;
      drain();
    end
    // stalled consumer: two pipeline stages plus fifo depth, then refusal
    @(posedge ref_clk_in);
    corrected_ready_in <= 1'b0;
    sample_in <= 24'(rnd());
    sample_valid_in <= 1'b1;
    n = 0;
    repeat (20) begin
      @(posedge ref_clk_in);
      if (sample_ready_out) begin
        exp_q.push_back(calc(sample_in, off_m, scl_m));
        n++;
        sample_in <= 24'(rnd());
      end
    end
    sample_valid_in <= 1'b0;
    check("accepted while stalled", 24'(n), 24'(`CAL_FIFO_DEPTH + 2));
    @(posedge ref_clk_in) corrected_ready_in <= 1'b1;
    drain();
    test_done();
  end
endmodule : tb_top
